// file: hdl/arg_pkg.sv
/*
  Shared constants for the current-routing and pin configuration registers.
  Assumes a command decoder on the device clock presents register accesses.
*/
package arg_pkg;
  localparam logic [7:0] ADDR_ROUTE = 8'h03;
  localparam logic [7:0] ADDR_PIN = 8'h04;
  localparam logic [7:0] RESET_ROUTE = 8'h00;
  localparam logic [7:0] RESET_PIN = 8'h00;
  localparam int SRC_A_LSB = 5;
  localparam int SRC_B_LSB = 2;
  localparam int AUTO_BIT = 0;
  localparam int DIR_LSB = 4;
  localparam int SEL_BIT = 3;
  localparam int LVL_LSB = 0;
  localparam int NUM_PINS = 3;
  localparam int NUM_TARGETS = 6;
  localparam logic [2:0] ROUTE_OFF = 3'h0;
  localparam logic [2:0] ROUTE_ANALOG_IN_0 = 3'h1;
  localparam logic [2:0] ROUTE_ANALOG_IN_1 = 3'h2;
  localparam logic [2:0] ROUTE_ANALOG_IN_2 = 3'h3;
  localparam logic [2:0] ROUTE_ANALOG_IN_3 = 3'h4;
  localparam logic [2:0] ROUTE_REF_POS = 3'h5;
  localparam logic [2:0] ROUTE_REF_NEG = 3'h6;
  localparam logic [2:0] ROUTE_RSVD = 3'h7;
endpackage

// file: hdl/arg_pin_sync.sv
/*
  Three-stage synchroniser for asynchronous pin levels.
  Assumes pins are quiet or slow relative to the device clock.
*/
`timescale 1ns/1ps
module arg_pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_stable
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] mid_r;
  logic [WIDTH-1:0] last_r;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] stable_nxt;

  // A change is accepted only once the second and third stages agree.
  assign agree = ~(mid_r ^ last_r);
  assign stable_nxt = (agree & mid_r) | (~agree & pin_stable);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      mid_r <= '0;
      last_r <= '0;
      pin_stable <= '0;
    end else begin
      meta_r <= pin_async;
      mid_r <= meta_r;
      last_r <= mid_r;
      pin_stable <= stable_nxt;
    end
  end
endmodule

// file: hdl/arg_cfg_regs.sv
/*
  Excitation routing, readout mode and general-purpose pin configuration registers.
  Assumes the serial command decoder runs on ref_clk and issues one-cycle strobes.
*/
`timescale 1ns/1ps
module arg_cfg_regs (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic conv_done,
  input wire logic data_read,
  output logic result_ready,
  output logic [2:0] src_a_route,
  output logic [2:0] src_b_route,
  output logic auto_read,
  output logic [arg_pkg::NUM_TARGETS-1:0] excite_src_a_conn,
  output logic [arg_pkg::NUM_TARGETS-1:0] excite_src_b_conn,
  input wire logic [arg_pkg::NUM_PINS-1:0] pin_pad_in,
  output logic [arg_pkg::NUM_PINS-1:0] pin_pad_out,
  output logic [arg_pkg::NUM_PINS-1:0] pin_pad_oe
);
  import arg_pkg::*;

  logic [2:0] route_a_r;
  logic [2:0] route_b_r;
  logic auto_r;
  logic [NUM_PINS-1:0] dir_r;
  logic sel_r;
  logic [NUM_PINS-1:0] lvl_r;
  logic ready_r;
  logic [NUM_TARGETS-1:0] conn_a_r;
  logic [NUM_TARGETS-1:0] conn_b_r;
  logic [NUM_PINS-1:0] pad_out_r;
  logic [NUM_PINS-1:0] pad_oe_r;
  logic [7:0] rdata_r;
  logic rvalid_r;

  wire route_wr = reg_wr && (reg_addr == ADDR_ROUTE);
  wire pin_wr = reg_wr && (reg_addr == ADDR_PIN);
  wire [NUM_PINS-1:0] dir_nxt = pin_wr ? reg_wdata[DIR_LSB +: NUM_PINS] : dir_r;
  wire [NUM_PINS-1:0] lvl_wdata = reg_wdata[LVL_LSB +: NUM_PINS];
  wire [NUM_PINS-1:0] pin_stable;
  wire [NUM_PINS-1:0] lvl_nxt;
  wire [NUM_PINS-1:0] drive_val;
  // Set wins over clear so a result landing during a read is never lost.
  wire ready_nxt = conv_done | (ready_r & ~data_read);
  wire [7:0] route_view = {route_a_r, route_b_r, 1'b0, auto_r};
  wire [7:0] pin_view = {1'b0, dir_r, sel_r, lvl_r};
  wire [7:0] rd_mux = (reg_addr == ADDR_ROUTE) ? route_view :
                      (reg_addr == ADDR_PIN) ? pin_view : 8'h00;

  arg_pin_sync #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_async(pin_pad_in),
    .pin_stable(pin_stable)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      // Inputs track the pin; outputs keep the written level.
      assign lvl_nxt[gi] = dir_nxt[gi] ? (pin_wr ? lvl_wdata[gi] : lvl_r[gi]) :
                           pin_stable[gi];
      if (gi == NUM_PINS - 1) begin : g_ready
        assign drive_val[gi] = sel_r ? ready_r : lvl_r[gi];
      end else begin : g_plain
        assign drive_val[gi] = lvl_r[gi];
      end
    end
  endgenerate

  function automatic logic [NUM_TARGETS-1:0] route_conn(input logic [2:0] code);
    logic [NUM_TARGETS-1:0] conn;
    conn = '0;
    case (code)
      ROUTE_ANALOG_IN_0: conn = 6'h01;
      ROUTE_ANALOG_IN_1: conn = 6'h02;
      ROUTE_ANALOG_IN_2: conn = 6'h04;
      ROUTE_ANALOG_IN_3: conn = 6'h08;
      ROUTE_REF_POS: conn = 6'h10;
      ROUTE_REF_NEG: conn = 6'h20;
      default: conn = '0;
    endcase
    return conn;
  endfunction

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      route_a_r <= RESET_ROUTE[SRC_A_LSB +: 3];
      route_b_r <= RESET_ROUTE[SRC_B_LSB +: 3];
      auto_r <= RESET_ROUTE[AUTO_BIT];
    end else if (route_wr) begin
      route_a_r <= reg_wdata[SRC_A_LSB +: 3];
      route_b_r <= reg_wdata[SRC_B_LSB +: 3];
      auto_r <= reg_wdata[AUTO_BIT];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dir_r <= RESET_PIN[DIR_LSB +: NUM_PINS];
      sel_r <= RESET_PIN[SEL_BIT];
      lvl_r <= RESET_PIN[LVL_LSB +: NUM_PINS];
    end else begin
      dir_r <= dir_nxt;
      sel_r <= pin_wr ? reg_wdata[SEL_BIT] : sel_r;
      lvl_r <= lvl_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ready_r <= 1'b0;
      conn_a_r <= '0;
      conn_b_r <= '0;
      pad_out_r <= '0;
      pad_oe_r <= '0;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      ready_r <= ready_nxt;
      conn_a_r <= route_conn(route_a_r);
      conn_b_r <= route_conn(route_b_r);
      pad_out_r <= drive_val;
      pad_oe_r <= dir_r;
      rdata_r <= reg_rd ? rd_mux : rdata_r;
      rvalid_r <= reg_rd;
    end
  end

  assign result_ready = ready_r;
  assign src_a_route = route_a_r;
  assign src_b_route = route_b_r;
  assign auto_read = auto_r;
  assign excite_src_a_conn = conn_a_r;
  assign excite_src_b_conn = conn_b_r;
  assign pin_pad_out = pad_out_r;
  assign pin_pad_oe = pad_oe_r;
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  route_a_posref_a: assert property ((route_a_r == ROUTE_REF_POS) |=>
    (excite_src_a_conn == 6'h10)) else $error("Source A not on positive reference.");
  route_b_off_a: assert property ((route_b_r == ROUTE_OFF ||
    route_b_r == ROUTE_RSVD) |=> (excite_src_b_conn == 6'h00))
    else $error("Source B connected while off.");
  auto_mode_a: assert property (route_wr |=>
    (auto_read == $past(reg_wdata[AUTO_BIT]))) else $error("Readout mode not updated.");
  pin_dir_oe_a: assert property (pin_wr |=> ##1
    (pin_pad_oe == $past(reg_wdata[DIR_LSB +: NUM_PINS], 2))) else $error("Enable mismatch.");
  pin2_ready_a: assert property ((dir_r[2] && sel_r) |=>
    (pin_pad_out[2] == $past(ready_r))) else $error("Pin two not showing ready.");
  pin0_drive_a: assert property (dir_r[0] |=>
    (pin_pad_out[0] == $past(lvl_r[0]))) else $error("Pin zero level wrong.");
  pin1_sample_a: assert property ((!pin_wr && !dir_r[1]) |=>
    (lvl_r[1] == $past(pin_stable[1]))) else $error("Input level not sampled.");
  pin_reg_read_a: assert property ((reg_rd && reg_addr == ADDR_PIN) |=>
    (reg_rdata == {1'b0, $past(dir_r), $past(sel_r), $past(lvl_r)}))
    else $error("Pin register read wrong.");
  route_rsvd_a: assert property ((reg_rd && reg_addr == ADDR_ROUTE) |=>
    (reg_rdata[1] == 1'b0)) else $error("Reserved bit reads one.");
  ready_set_a: assert property (conv_done |=> result_ready)
    else $error("Ready flag lost its set.");
  ready_clear_a: assert property ((data_read && !conv_done) |=> !result_ready)
    else $error("Ready flag not cleared.");

  // Stored codes and the mode bit change only on a write to the routing register.
  route_a_store_a: assert property (route_wr |=>
    (src_a_route == $past(reg_wdata[SRC_A_LSB +: 3])))
    else $error("Source A code not stored.");
  route_b_store_a: assert property (route_wr |=>
    (src_b_route == $past(reg_wdata[SRC_B_LSB +: 3])))
    else $error("Source B code not stored.");
  route_a_hold_a: assert property (!route_wr |=>
    $stable(src_a_route))
    else $error("Source A code changed without a write.");
  auto_hold_a: assert property (!route_wr |=>
    $stable(auto_read))
    else $error("Readout mode changed without a write.");
  route_a_off_a: assert property ((route_a_r == ROUTE_OFF ||
    route_a_r == ROUTE_RSVD) |=> (excite_src_a_conn == 6'h00))
    else $error("Source A connected while off.");
  route_b_negref_a: assert property ((route_b_r == ROUTE_REF_NEG) |=>
    (excite_src_b_conn == 6'h20))
    else $error("Source B not on negative reference.");
  route_a_in3_a: assert property ((route_a_r == ROUTE_ANALOG_IN_3) |=>
    (excite_src_a_conn == 6'h08))
    else $error("Source A not on analog input three.");
  pin_oe_follow_a: assert property (1'b1 |=>
    (pin_pad_oe == $past(dir_r)))
    else $error("Pad enable does not follow direction.");
  pin2_level_a: assert property ((dir_r[2] && !sel_r) |=>
    (pin_pad_out[2] == $past(lvl_r[2])))
    else $error("Pin two not showing its level bit.");
  pin1_drive_a: assert property (dir_r[1] |=>
    (pin_pad_out[1] == $past(lvl_r[1])))
    else $error("Pin one level wrong.");
  out_level_keep_a: assert property ((!pin_wr && dir_r[0]) |=>
    (lvl_r[0] == $past(lvl_r[0])))
    else $error("Output level bit changed without a write.");
  pin2_sample_a: assert property ((!pin_wr && !dir_r[2]) |=>
    (lvl_r[2] == $past(pin_stable[2])))
    else $error("Pin two input level not sampled.");
  pin_rsvd_a: assert property ((reg_rd && reg_addr == ADDR_PIN) |=>
    (reg_rdata[7] == 1'b0))
    else $error("Reserved pin bit reads one.");
  route_read_a: assert property ((reg_rd && reg_addr == ADDR_ROUTE) |=>
    (reg_rdata == {$past(route_a_r), $past(route_b_r), 1'b0, $past(auto_r)}))
    else $error("Routing register read wrong.");
  unmapped_read_a: assert property ((reg_rd && reg_addr != ADDR_ROUTE &&
    reg_addr != ADDR_PIN) |=> (reg_rdata == 8'h00))
    else $error("Unmapped address reads nonzero.");
  ready_hold_a: assert property ((result_ready && !data_read) |=>
    result_ready)
    else $error("Ready flag dropped without a read.");
  ready_rise_a: assert property ($rose(result_ready) |->
    $past(conv_done))
    else $error("Ready flag rose without a result.");
endmodule

// file: tb/arg_host_model.sv
/*
  Host-side model that issues decoded register accesses to the block.
  Assumes the bench calls wr and rd; all strobes change on falling edges.
*/
`timescale 1ns/1ps
module arg_host_model (
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Each call stands for one command already framed behind its sync word.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
  endtask
endmodule

// file: tb/adc_routing_gpio_cfg_regs_test.sv
/*
  Self-checking bench for the routing and pin configuration registers.
  Assumes the host model drives the register strobes and pads are resolved here.
*/
`timescale 1ns/1ps
module adc_routing_gpio_cfg_regs_test;
  import arg_pkg::*;
  logic ref_clk, reset, reg_wr, reg_rd, reg_rvalid, conv_done, data_read, result_ready, auto_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic [2:0] src_a_route, src_b_route, pin_pad_out, pin_pad_oe, pad_ext;
  wire [2:0] pin_pad_in;
  logic [5:0] conn_a, conn_b;
  int num_errors = 0;
  int n_tests = 0;
  logic [31:0] rows [8] = '{32'h1E1C0000, 32'h3B390120, 32'h56540210, 32'h73710408,
    32'h8E8C0804, 32'hABA91002, 32'hC6C42001, 32'hE3E10000};
  assign pin_pad_in = (pin_pad_oe & pin_pad_out) | (~pin_pad_oe & pad_ext);
  arg_cfg_regs uut (.ref_clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid, .conv_done, .data_read, .result_ready, .src_a_route, .src_b_route,
    .auto_read, .excite_src_a_conn(conn_a), .excite_src_b_conn(conn_b), .pin_pad_in,
    .pin_pad_out, .pin_pad_oe);
  arg_host_model host (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic pulse(input logic set_in, input logic clr_in);
    @(negedge ref_clk);
    conv_done = set_in;
    data_read = clr_in;
    @(negedge ref_clk);
    conv_done = 1'b0;
    data_read = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  initial begin
    #20000;
    num_errors++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    conv_done = 1'b0;
    data_read = 1'b0;
    pad_ext = 3'h0;
    repeat (4) @(negedge ref_clk);
    reset = 1'b0;
    host.rd(ADDR_ROUTE, v);
    chk("route reset", v, 8'h00);
    host.rd(ADDR_PIN, v);
    chk("pin reset", v, 8'h00);
    chk("oe reset", {5'h00, pin_pad_oe}, 8'h00);
    foreach (rows[i]) begin
      host.wr(ADDR_ROUTE, rows[i][31:24]);
      host.rd(ADDR_ROUTE, v);
      chk("route read", v, rows[i][23:16]);
      chk("src a", {5'h00, src_a_route}, {5'h00, rows[i][31:29]});
      chk("src b", {5'h00, src_b_route}, {5'h00, rows[i][28:26]});
      chk("auto", {7'h00, auto_read}, {7'h00, rows[i][24]});
      chk("conn a", {2'h0, conn_a}, rows[i][15:8]);
      chk("conn b", {2'h0, conn_b}, rows[i][7:0]);
    end
    host.wr(8'h05, 8'hFF);
    host.rd(8'h05, v);
    chk("unmapped", v, 8'h00);
    pad_ext = 3'h5;
    host.wr(ADDR_PIN, 8'hF2);
    host.rd(ADDR_PIN, v);
    chk("pin read", v, 8'h72);
    chk("oe out", {5'h00, pin_pad_oe}, 8'h07);
    chk("pad out", {5'h00, pin_pad_out}, 8'h02);
    host.wr(ADDR_PIN, 8'h7C);
    repeat (2) @(negedge ref_clk);
    chk("ready idle", {5'h00, pin_pad_out}, 8'h00);
    pulse(1'b1, 1'b0);
    chk("ready set", {7'h00, result_ready}, 8'h01);
    chk("ready pad", {5'h00, pin_pad_out}, 8'h04);
    pulse(1'b0, 1'b1);
    chk("ready clr", {7'h00, result_ready}, 8'h00);
    chk("ready pad clr", {5'h00, pin_pad_out}, 8'h00);
    host.wr(ADDR_PIN, 8'h00);
    repeat (6) @(negedge ref_clk);
    host.rd(ADDR_PIN, v);
    chk("in sample", v, 8'h05);
    chk("oe in", {5'h00, pin_pad_oe}, 8'h00);
    pad_ext = 3'h2;
    repeat (6) @(negedge ref_clk);
    host.rd(ADDR_PIN, v);
    chk("in track", v, 8'h02);
    pulse(1'b1, 1'b1);
    chk("set wins", {7'h00, result_ready}, 8'h01);
    pulse(1'b0, 1'b1);
    chk("ready clr2", {7'h00, result_ready}, 8'h00);
    host.wr(ADDR_PIN, 8'h45);
    host.rd(ADDR_PIN, v);
    chk("pin2 out read", v, 8'h46);
    chk("pin2 data", {5'h00, pin_pad_out & pin_pad_oe}, 8'h04);
    host.wr(ADDR_PIN, 8'h17);
    repeat (6) @(negedge ref_clk);
    host.rd(ADDR_PIN, v);
    chk("pin0 out read", v, 8'h13);
    chk("pin0 data", {5'h00, pin_pad_out & pin_pad_oe}, 8'h01);
    host.wr(ADDR_ROUTE, 8'hAB);
    pulse(1'b1, 1'b0);
    pad_ext = 3'h0;
    @(negedge ref_clk);
    reset = 1'b1;
    @(negedge ref_clk);
    chk("rst ready", {7'h00, result_ready}, 8'h00);
    chk("rst auto", {7'h00, auto_read}, 8'h00);
    chk("rst conn", {2'h0, conn_a}, 8'h00);
    chk("rst oe", {5'h00, pin_pad_oe}, 8'h00);
    chk("rst pad", {5'h00, pin_pad_out}, 8'h00);
    reset = 1'b0;
    host.rd(ADDR_ROUTE, v);
    chk("rst route", v, 8'h00);
    host.rd(ADDR_PIN, v);
    chk("rst pin", v, 8'h00);
    end_sim();
  end
endmodule
